// *** core/bwlm_top.v ***
`timescale 1ns/1ps
`include "bwlm_defines.vh"

// What this block does
// - x8: low-half select low alone stores bits 3..0, keeps 7..4
// - x8: high-half select low alone stores bits 7..4, keeps 3..0
// - x8/x18: both low stores all; x18 single select stores its 9-bit lane
// - x8/x18: both selects high means the beat stores nothing
// - x9: one select; low stores bits 8..0, high stores nothing
// - x36: all four selects low stores bits 35..0
// - x36: select 0 alone low stores bits 8..0 only
// - x36: select 1, 2 or 3 alone stores its own 9-bit lane
// - x9/x36: all selects high means the beat stores nothing
// - Selects sampled on both positive and negative clock rises, once per beat; the negative rise right after the start is skipped
// - Selects only matter on beats of a properly started write burst
// - Beats arrive on alternating rises, four words to consecutive addresses
module bwlm_top #(
  parameter MODE = `BWLM_MODE_X36,
  parameter ADDR_W = `BWLM_ADDR_W
) (
  // Clock and reset
  input wire MCLK,
  input wire RST,
  // Input clock rise indications
  input wire POS_CLK_RISE,
  input wire NEG_CLK_RISE,
  // Write request
  input wire WRITE_PORT_SEL_N,
  input wire [ADDR_W-1:0] WRITE_ADDR,
  // Write data and lane selects
  input wire [`BWLM_DW_MAX-1:0] WRITE_DATA,
  input wire LANE_WRITE_SELECT_0_N,
  input wire LANE_WRITE_SELECT_1_N,
  input wire LANE_WRITE_SELECT_2_N,
  input wire LANE_WRITE_SELECT_3_N,
  input wire LOW_HALF_LANE_SELECT_N,
  input wire HIGH_HALF_LANE_SELECT_N,
  // Inspection read port
  input wire READ_REQ,
  input wire [ADDR_W+1:0] READ_ADDR,
  output reg READ_VALID,
  output reg [`BWLM_DW_MAX-1:0] READ_DATA,
  // Status
  output reg WRITE_ACTIVE,
  output reg BURST_DONE,
  output reg START_IGNORED,
  output reg BEAT_SKIPPED,
  output reg BEAT_LOST,
  output reg BEAT_READY
);

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam DW = (MODE == `BWLM_MODE_X8) ? `BWLM_DW_X8 :
                  (MODE == `BWLM_MODE_X9) ? `BWLM_DW_X9 :
                  (MODE == `BWLM_MODE_X18) ? `BWLM_DW_X18 : `BWLM_DW_X36;
  localparam LANE_W = (MODE == `BWLM_MODE_X8) ? `BWLM_LANE_W_X8 : `BWLM_LANE_W_WIDE;
  localparam WA_W = ADDR_W + `BWLM_BEAT_IDX_W;
  localparam ENTRY_W = WA_W + DW + DW;

  // ----------------------------------------
  // Lane selects to bit mask
  // ----------------------------------------
  // x8 uses the two half selects; unused lanes in narrow modes stay deselected
  reg [`BWLM_SEL_COUNT-1:0] sel_n;
  always @* begin
    case (MODE)
      `BWLM_MODE_X8:
        sel_n = {2'h3, HIGH_HALF_LANE_SELECT_N, LOW_HALF_LANE_SELECT_N};
      `BWLM_MODE_X9:
        sel_n = {3'h7, LANE_WRITE_SELECT_0_N};
      `BWLM_MODE_X18:
        sel_n = {2'h3, LANE_WRITE_SELECT_1_N, LANE_WRITE_SELECT_0_N};
      default:
        sel_n = {LANE_WRITE_SELECT_3_N, LANE_WRITE_SELECT_2_N,
                 LANE_WRITE_SELECT_1_N, LANE_WRITE_SELECT_0_N};
    endcase
  end

  wire [DW-1:0] beat_mask;
  genvar gi;
  generate
    for (gi = 0; gi < DW; gi = gi + 1) begin : g_mask
      assign beat_mask[gi] = ~sel_n[gi / LANE_W];
    end
  endgenerate

  // All selects high: nothing to store
  wire beat_empty = ~|beat_mask;

  // ----------------------------------------
  // Burst sequencer
  // ----------------------------------------
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [ADDR_W-1:0] addr_reg;
  reg [ADDR_W-1:0] addr_next;
  reg [ADDR_W-1:0] pend_addr_reg;
  reg [ADDR_W-1:0] pend_addr_next;
  reg pend_reg;
  reg pend_next;
  reg last_start_reg;
  reg last_start_next;
  reg beat_take;
  reg [`BWLM_BEAT_IDX_W-1:0] beat_idx;
  reg start_ok;
  reg start_rej;
  reg done_now;

  wire start_req = POS_CLK_RISE & ~WRITE_PORT_SEL_N;

  always @* begin
    state_next = state_reg;
    addr_next = addr_reg;
    pend_addr_next = pend_addr_reg;
    pend_next = pend_reg;
    last_start_next = last_start_reg;
    beat_take = 1'b0;
    beat_idx = 2'h0;
    start_ok = 1'b0;
    start_rej = 1'b0;
    done_now = 1'b0;
    // A start on the next positive rise after an accepted start is dropped
    if (POS_CLK_RISE) begin
      start_ok = start_req & ~last_start_reg;
      start_rej = start_req & last_start_reg;
      last_start_next = start_ok;
    end
    case (state_reg)
      `BWLM_ST_IDLE: begin
        if (start_ok) begin
          addr_next = WRITE_ADDR;
          state_next = `BWLM_ST_BEAT0;
        end
      end
      `BWLM_ST_BEAT0: begin
        if (POS_CLK_RISE) begin
          beat_take = 1'b1;
          beat_idx = 2'h0;
          state_next = `BWLM_ST_BEAT1;
        end
      end
      `BWLM_ST_BEAT1: begin
        if (NEG_CLK_RISE) begin
          beat_take = 1'b1;
          beat_idx = 2'h1;
          state_next = `BWLM_ST_BEAT2;
        end
      end
      `BWLM_ST_BEAT2: begin
        // Next burst may start on this same rise
        if (POS_CLK_RISE) begin
          beat_take = 1'b1;
          beat_idx = 2'h2;
          state_next = `BWLM_ST_BEAT3;
          if (start_ok) begin
            pend_next = 1'b1;
            pend_addr_next = WRITE_ADDR;
          end
        end
      end
      `BWLM_ST_BEAT3: begin
        if (NEG_CLK_RISE) begin
          beat_take = 1'b1;
          beat_idx = 2'h3;
          done_now = 1'b1;
          if (pend_reg) begin
            pend_next = 1'b0;
            addr_next = pend_addr_reg;
            state_next = `BWLM_ST_BEAT0;
          end else begin
            state_next = `BWLM_ST_IDLE;
          end
        end
      end
      default: begin
        state_next = `BWLM_ST_IDLE;
        pend_next = 1'b0;
      end
    endcase
  end

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_reg <= `BWLM_RST_STATE;
      addr_reg <= {ADDR_W{1'b0}};
      pend_addr_reg <= {ADDR_W{1'b0}};
      pend_reg <= `BWLM_RST_FLAG;
      last_start_reg <= `BWLM_RST_FLAG;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      pend_addr_reg <= pend_addr_next;
      pend_reg <= pend_next;
      last_start_reg <= last_start_next;
    end
  end

  // ----------------------------------------
  // Beat capture into the buffer
  // ----------------------------------------
  // Selects outside a burst beat never reach the buffer
  wire beat_store = beat_take & ~beat_empty;
  wire [WA_W-1:0] beat_waddr = {addr_reg, beat_idx};
  wire [ENTRY_W-1:0] beat_entry = {beat_waddr, beat_mask, WRITE_DATA[DW-1:0]};

  wire buf_in_ready;
  wire buf_out_valid;
  wire [ENTRY_W-1:0] buf_out_data;
  wire buf_out_ready;

  bwlm_skid #(
    .W(ENTRY_W)
  ) u_skid (
    .clk(MCLK),
    .rst(RST),
    .in_valid(beat_store),
    .in_data(beat_entry),
    .in_ready(buf_in_ready),
    .out_valid(buf_out_valid),
    .out_data(buf_out_data),
    .out_ready(buf_out_ready)
  );

  // ----------------------------------------
  // Array access
  // ----------------------------------------
  // Reads win over array writes, so a long read run stalls the drain
  assign buf_out_ready = ~READ_REQ;
  wire mem_we = buf_out_valid & buf_out_ready;
  wire [DW-1:0] mem_rdata;

  bwlm_mem #(
    .AW(WA_W),
    .DW(DW)
  ) u_mem (
    .clk(MCLK),
    .we(mem_we),
    .waddr(buf_out_data[ENTRY_W-1:DW+DW]),
    .wdata(buf_out_data[DW-1:0]),
    .wmask(buf_out_data[DW+DW-1:DW]),
    .re(READ_REQ),
    .raddr(READ_ADDR),
    .rdata(mem_rdata)
  );

  // ----------------------------------------
  // Read return
  // ----------------------------------------
  reg rd_pend_reg;
  wire [`BWLM_DW_MAX-1:0] rdata_wide;
  generate
    if (DW < `BWLM_DW_MAX) begin : g_pad
      assign rdata_wide = {{(`BWLM_DW_MAX-DW){1'b0}}, mem_rdata};
    end else begin : g_full
      assign rdata_wide = mem_rdata;
    end
  endgenerate

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rd_pend_reg <= `BWLM_RST_FLAG;
      READ_VALID <= `BWLM_RST_FLAG;
      READ_DATA <= {`BWLM_DW_MAX{1'b0}};
    end else begin
      rd_pend_reg <= READ_REQ;
      READ_VALID <= rd_pend_reg;
      if (rd_pend_reg)
        READ_DATA <= rdata_wide;
    end
  end

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      WRITE_ACTIVE <= `BWLM_RST_FLAG;
      BURST_DONE <= `BWLM_RST_FLAG;
      START_IGNORED <= `BWLM_RST_FLAG;
      BEAT_SKIPPED <= `BWLM_RST_FLAG;
      BEAT_LOST <= `BWLM_RST_FLAG;
      BEAT_READY <= `BWLM_RST_READY;
    end else begin
      WRITE_ACTIVE <= (state_next != `BWLM_ST_IDLE);
      BURST_DONE <= done_now;
      START_IGNORED <= start_rej;
      BEAT_SKIPPED <= beat_take & beat_empty;
      BEAT_LOST <= beat_store & ~buf_in_ready;
      BEAT_READY <= buf_in_ready;
    end
  end

endmodule

// *** inc/bwlm_defines.vh ***
`ifndef BWLM_DEFINES_VH
`define BWLM_DEFINES_VH

// ----------------------------------------
// Width modes
// ----------------------------------------
`define BWLM_MODE_X8 2'h0
`define BWLM_MODE_X9 2'h1
`define BWLM_MODE_X18 2'h2
`define BWLM_MODE_X36 2'h3

// ----------------------------------------
// Word and lane geometry per mode
// ----------------------------------------
`define BWLM_DW_X8 8
`define BWLM_DW_X9 9
`define BWLM_DW_X18 18
`define BWLM_DW_X36 36
`define BWLM_LANE_W_X8 4
`define BWLM_LANE_W_WIDE 9
`define BWLM_DW_MAX 36
`define BWLM_SEL_COUNT 4

// ----------------------------------------
// Burst geometry
// ----------------------------------------
`define BWLM_BURST_LEN 4
`define BWLM_BEAT_IDX_W 2
`define BWLM_ADDR_W 21

// ----------------------------------------
// Burst sequencer states
// ----------------------------------------
`define BWLM_ST_IDLE 3'h0
`define BWLM_ST_BEAT0 3'h1
`define BWLM_ST_BEAT1 3'h2
`define BWLM_ST_BEAT2 3'h3
`define BWLM_ST_BEAT3 3'h4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BWLM_RST_STATE 3'h0
`define BWLM_RST_COUNT 2'h0
`define BWLM_RST_READY 1'h1
`define BWLM_RST_FLAG 1'h0

`endif

// *** core/bwlm_skid.v ***
`timescale 1ns/1ps
`include "bwlm_defines.vh"

module bwlm_skid #(
  parameter W = 8
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Filling side
  input wire in_valid,
  input wire [W-1:0] in_data,
  output reg in_ready,
  // Draining side
  output reg out_valid,
  output reg [W-1:0] out_data,
  input wire out_ready
);

  reg [W-1:0] spare_reg;
  reg [1:0] count_reg;
  reg [1:0] count_next;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  always @* begin
    count_next = count_reg;
    if (push && !pop)
      count_next = count_reg + 2'h1;
    else if (pop && !push)
      count_next = count_reg - 2'h1;
  end

  // Flags are registered from the next count so both ports see flop outputs
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= `BWLM_RST_COUNT;
      in_ready <= `BWLM_RST_READY;
      out_valid <= `BWLM_RST_FLAG;
      out_data <= {W{1'b0}};
      spare_reg <= {W{1'b0}};
    end else begin
      count_reg <= count_next;
      in_ready <= (count_next != 2'h2);
      out_valid <= (count_next != 2'h0);
      if (push && pop) begin
        if (count_reg == 2'h1) begin
          out_data <= in_data;
        end else begin
          out_data <= spare_reg;
          spare_reg <= in_data;
        end
      end else if (pop) begin
        out_data <= spare_reg;
      end else if (push) begin
        if (count_reg == 2'h0)
          out_data <= in_data;
        else
          spare_reg <= in_data;
      end
    end
  end

endmodule

// *** core/bwlm_mem.v ***
`timescale 1ns/1ps
`include "bwlm_defines.vh"

module bwlm_mem #(
  parameter AW = 8,
  parameter DW = 8
) (
  // Clock
  input wire clk,
  // Masked write port
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  input wire [DW-1:0] wmask,
  // Read port
  input wire re,
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Masked bits keep their stored value
  always @(posedge clk) begin
    if (we)
      mem[waddr] <= (mem[waddr] & ~wmask) | (wdata & wmask);
    if (re)
      rdata <= mem[raddr];
  end

endmodule

// *** verification/bwlm_properties.sv ***
`timescale 1ns/1ps
`include "bwlm_defines.vh"
module bwlm_props #(
  parameter MODE = `BWLM_MODE_X36,
  parameter ADDR_W = `BWLM_ADDR_W
) (
  // Clock and reset
  input wire MCLK,
  input wire RST,
  // Controller side
  input wire POS_CLK_RISE,
  input wire NEG_CLK_RISE,
  input wire WRITE_PORT_SEL_N,
  input wire [ADDR_W-1:0] WRITE_ADDR,
  input wire [`BWLM_DW_MAX-1:0] WRITE_DATA,
  input wire LANE_WRITE_SELECT_0_N,
  input wire LANE_WRITE_SELECT_1_N,
  input wire LANE_WRITE_SELECT_2_N,
  input wire LANE_WRITE_SELECT_3_N,
  input wire LOW_HALF_LANE_SELECT_N,
  input wire HIGH_HALF_LANE_SELECT_N,
  // Read port
  input wire READ_REQ,
  input wire [ADDR_W+1:0] READ_ADDR,
  input wire READ_VALID,
  input wire [`BWLM_DW_MAX-1:0] READ_DATA,
  // Status
  input wire WRITE_ACTIVE,
  input wire BURST_DONE,
  input wire START_IGNORED,
  input wire BEAT_SKIPPED,
  input wire BEAT_LOST,
  input wire BEAT_READY
);
  wire [3:0] bw_n = {LANE_WRITE_SELECT_3_N, LANE_WRITE_SELECT_2_N, LANE_WRITE_SELECT_1_N, LANE_WRITE_SELECT_0_N};
  wire nib_hi = LOW_HALF_LANE_SELECT_N && HIGH_HALF_LANE_SELECT_N;
  wire all_hi = MODE == 3 ? &bw_n : MODE == 2 ? &bw_n[1:0] : MODE == 1 ? bw_n[0] : nib_hi;
  wire start = POS_CLK_RISE && !WRITE_PORT_SEL_N && !WRITE_ACTIVE;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence s_start;
    start;
  endsequence
  // Second request on the very next positive rise
  sequence s_twin;
    s_start ##1 !POS_CLK_RISE ##1 POS_CLK_RISE && !WRITE_PORT_SEL_N;
  endsequence
  a_start_holds_busy: assert property (s_start |=> WRITE_ACTIVE [*5])
    else $error("busy level dropped inside a burst");
  a_done_after_six: assert property (s_start |-> ##6 BURST_DONE)
    else $error("burst end not flagged in time");
  a_done_cause: assert property (BURST_DONE |-> $past(NEG_CLK_RISE) && $past(WRITE_ACTIVE))
    else $error("burst end without a last beat");
  a_twin_refused: assert property (s_twin |=> START_IGNORED)
    else $error("back to back start not refused");
  a_ignore_cause: assert property (START_IGNORED |-> $past(WRITE_ACTIVE) && !$past(WRITE_PORT_SEL_N))
    else $error("refusal without a request");
  a_skip_first: assert property (s_start ##2 all_hi |=> BEAT_SKIPPED)
    else $error("all high beat not skipped");
  a_kept_beat: assert property (s_start ##3 !all_hi |=> !BEAT_SKIPPED)
    else $error("enabled beat reported skipped");
  a_skip_cause: assert property (BEAT_SKIPPED |-> $past(all_hi) && $past(WRITE_ACTIVE))
    else $error("skip outside a burst beat");
  a_read_two: assert property (READ_REQ |-> ##2 READ_VALID)
    else $error("read answer late");
endmodule
bind bwlm_top bwlm_props #(.MODE(MODE), .ADDR_W(ADDR_W)) u_props (
  .MCLK(MCLK), .RST(RST), .POS_CLK_RISE(POS_CLK_RISE), .NEG_CLK_RISE(NEG_CLK_RISE),
  .WRITE_PORT_SEL_N(WRITE_PORT_SEL_N), .WRITE_ADDR(WRITE_ADDR), .WRITE_DATA(WRITE_DATA),
  .LANE_WRITE_SELECT_0_N(LANE_WRITE_SELECT_0_N), .LANE_WRITE_SELECT_1_N(LANE_WRITE_SELECT_1_N),
  .LANE_WRITE_SELECT_2_N(LANE_WRITE_SELECT_2_N), .LANE_WRITE_SELECT_3_N(LANE_WRITE_SELECT_3_N),
  .LOW_HALF_LANE_SELECT_N(LOW_HALF_LANE_SELECT_N), .HIGH_HALF_LANE_SELECT_N(HIGH_HALF_LANE_SELECT_N),
  .READ_REQ(READ_REQ), .READ_ADDR(READ_ADDR), .READ_VALID(READ_VALID), .READ_DATA(READ_DATA),
  .WRITE_ACTIVE(WRITE_ACTIVE), .BURST_DONE(BURST_DONE), .START_IGNORED(START_IGNORED),
  .BEAT_SKIPPED(BEAT_SKIPPED), .BEAT_LOST(BEAT_LOST), .BEAT_READY(BEAT_READY));

// *** verification/bwlm_ctrl_model.sv ***
`timescale 1ns/1ps
module bwlm_ctrl_model (
  // Clock
  input wire MCLK,
  // Drive to the block
  output reg pos,
  output reg neg,
  output reg sel_n,
  output reg [3:0] addr,
  output reg [35:0] data,
  output reg [3:0] bw_n
);
  initial begin
    pos = 0;
    neg = 0;
    sel_n = 1;
    addr = 0;
    data = 0;
    bw_n = 0;
  end
  // Input clocks run free, rises alternate
  always @(posedge MCLK) begin
    #1;
    pos <= !pos;
    neg <= pos;
  end
  task burst(input [3:0] a, input [143:0] d, input [15:0] m, input bb);
    integer i;
    begin
      @(posedge MCLK);
      // Input clocks alternate, so one extra edge at most
      if (pos) @(posedge MCLK);
      #1 sel_n <= 0;
      addr <= a;
      @(posedge MCLK);
      #1 sel_n <= 1;
      data <= ~data;
      for (i = 0; i < 4; i = i + 1) begin
        @(posedge MCLK);
        #1 sel_n <= !(bb && i == 0);
        data <= d[i*36 +: 36];
        bw_n <= m[i*4 +: 4];
      end
      @(posedge MCLK);
      // Selects left low: idle edges must store nothing
      #1 sel_n <= 1;
      data <= ~data;
      bw_n <= 0;
    end
  endtask
endmodule

// *** verification/bwlm_top_bench.sv ***
`timescale 1ns/1ps
`include "bwlm_defines.vh"
module bwlm_top_bench;
  reg MCLK = 0;
  reg RST = 1;
  reg READ_REQ = 0;
  reg [5:0] READ_ADDR = 0;
  wire pos, neg, sel_n, rv, act, done, ign, skip, lost, rdy;
  wire [3:0] wa, bw;
  wire [35:0] wd, rdat;
  wire [2:0] rvn;
  wire [107:0] rn;
  integer err_total = 0, total_checks = 0, seed = 32'hD2D99452;
  integer n_skip = 0, n_ign = 0, n_lost = 0, n_done = 0, e_skip = 0, e_done = 0;
  integer i, j, k;
  // Expected words indexed by {mode, word address}
  reg [35:0] mem [0:255];
  genvar g;
  reg [159:0] rnd;
  reg [15:0] m;
  always #50 MCLK = !MCLK;
  bwlm_ctrl_model p (.MCLK(MCLK), .pos(pos), .neg(neg), .sel_n(sel_n), .addr(wa), .data(wd), .bw_n(bw));
  bwlm_top #(.MODE(`BWLM_MODE_X36), .ADDR_W(4)) dut (
    .MCLK(MCLK), .RST(RST), .POS_CLK_RISE(pos), .NEG_CLK_RISE(neg),
    .WRITE_PORT_SEL_N(sel_n), .WRITE_ADDR(wa), .WRITE_DATA(wd),
    .LANE_WRITE_SELECT_0_N(bw[0]), .LANE_WRITE_SELECT_1_N(bw[1]),
    .LANE_WRITE_SELECT_2_N(bw[2]), .LANE_WRITE_SELECT_3_N(bw[3]),
    .LOW_HALF_LANE_SELECT_N(bw[0]), .HIGH_HALF_LANE_SELECT_N(bw[1]),
    .READ_REQ(READ_REQ), .READ_ADDR(READ_ADDR), .READ_VALID(rv), .READ_DATA(rdat),
    .WRITE_ACTIVE(act), .BURST_DONE(done), .START_IGNORED(ign),
    .BEAT_SKIPPED(skip), .BEAT_LOST(lost), .BEAT_READY(rdy));
  // Narrow widths share the controller, one instance per mode
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_narrow
      bwlm_top #(.MODE(g), .ADDR_W(4)) dut (
        .MCLK(MCLK), .RST(RST), .POS_CLK_RISE(pos), .NEG_CLK_RISE(neg),
        .WRITE_PORT_SEL_N(sel_n), .WRITE_ADDR(wa), .WRITE_DATA(wd),
        .LANE_WRITE_SELECT_0_N(bw[0]), .LANE_WRITE_SELECT_1_N(bw[1]),
        .LANE_WRITE_SELECT_2_N(bw[2]), .LANE_WRITE_SELECT_3_N(bw[3]),
        .LOW_HALF_LANE_SELECT_N(bw[0]), .HIGH_HALF_LANE_SELECT_N(bw[1]),
        .READ_REQ(READ_REQ), .READ_ADDR(READ_ADDR), .READ_VALID(rvn[g]), .READ_DATA(rn[g*36 +: 36]),
        .WRITE_ACTIVE(), .BURST_DONE(), .START_IGNORED(),
        .BEAT_SKIPPED(), .BEAT_LOST(), .BEAT_READY());
    end
  endgenerate
  // Mid-cycle sampling keeps clear of edge races
  always @(negedge MCLK) begin
    n_skip = n_skip + (skip === 1'b1);
    n_ign = n_ign + (ign === 1'b1);
    n_lost = n_lost + (lost === 1'b1);
    n_done = n_done + (done === 1'b1);
  end
  task cmp(input [35:0] got, input [35:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [15:0] mk, input bb);
    begin
      rnd = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
      for (i = 0; i < 4; i = i + 1) begin
        e_skip = e_skip + (mk[i*4 +: 4] == 4'hF);
        for (k = 0; k < 36; k = k + 1) begin
          if (!mk[i*4+k/9]) mem[{2'h3, a, i[1:0]}][k] = rnd[i*36+k];
          if (k < 18 && !mk[i*4+k/9]) mem[{2'h2, a, i[1:0]}][k] = rnd[i*36+k];
          if (k < 9 && !mk[i*4]) mem[{2'h1, a, i[1:0]}][k] = rnd[i*36+k];
          if (k < 8 && !mk[i*4+k/4]) mem[{2'h0, a, i[1:0]}][k] = rnd[i*36+k];
        end
      end
      e_done = e_done + 1;
      p.burst(a, rnd[143:0], mk, bb);
      repeat (2) @(posedge MCLK);
      #1;
    end
  endtask
  task rd(input [5:0] ad);
    begin
      READ_REQ = 1;
      READ_ADDR = ad;
      @(posedge MCLK);
      #1 READ_REQ = 0;
      // Valid stands for one cycle only
      @(posedge MCLK);
      #1 cmp({35'h0, rv}, 1);
      cmp(rdat, mem[{2'h3, ad}]);
      for (k = 0; k < 3; k = k + 1) begin
        cmp({35'h0, rvn[k]}, 1);
        cmp(rn[k*36 +: 36], mem[{k[1:0], ad}]);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    #1000000;
    err_total = err_total + 1;
    $display("CHECK FAILED %0t run did not finish", $time);
    end_of_test;
  end
  initial begin
    // Narrow words read back zero-extended
    for (j = 0; j < 256; j = j + 1)
      mem[j] = 36'h0;
    repeat (5) @(posedge MCLK);
    #1 RST = 0;
    cmp({35'h0, rdy}, 1);
    cmp({35'h0, act}, 0);
    for (j = 0; j < 16; j = j + 1)
      wr(j[3:0], 16'h0000, 0);
    for (j = 0; j < 64; j = j + 1)
      rd(j[5:0]);
    $display("full bursts done");
    for (j = 0; j < 12; j = j + 1) begin
      m = $random(seed);
      if (j < 4)
        for (i = 0; i < 4; i = i + 1) m[i*4 +: 4] = ~(4'h1 << ((i + j) % 4));
      if (j == 4)
        m = 16'hF00F;
      wr(j[3:0], m, 0);
    end
    wr(4'hC, 16'h0000, 1);
    $display("masked bursts done");
    // Reads hold off the drain so the buffer overflows
    READ_REQ = 1;
    wr(4'hD, 16'h0000, 0);
    READ_REQ = 0;
    cmp({35'h0, n_lost != 0}, 1);
    repeat (4) @(posedge MCLK);
    #1 cmp({35'h0, rdy}, 1);
    rd(6'h34);
    wr(4'hD, 16'h0000, 0);
    $display("stall done");
    for (j = 0; j < 64; j = j + 1)
      rd(j[5:0]);
    cmp(n_skip, e_skip);
    cmp(n_done, e_done);
    cmp(n_ign, 1);
    $display("readback done");
    end_of_test;
  end
endmodule
